/* core/aps_deglitch.sv */
`timescale 1ns/1ps
`include "aps_params.svh"

module aps_deglitch (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// raw pin and filtered level
	input  wire logic pin_n,
	output logic      filt_n
);
	localparam logic [7:0] CYC = 8'(`APS_DEGLITCH_CYC);

	logic       s1_reg;
	logic       s2_reg;
	logic [7:0] cnt_reg;

	// two-stage synchroniser, idle high like the pulled-up pin
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
		end else begin
			s1_reg <= pin_n;
			s2_reg <= s1_reg;
		end
	end

	// level must differ for the full window before it is taken
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= 8'h00;
			filt_n  <= 1'b1;
		end else if (s2_reg == filt_n) begin
			cnt_reg <= 8'h00; // any bounce restarts the window
		end else if (cnt_reg == CYC - 8'h01) begin
			cnt_reg <= 8'h00;
			filt_n  <= s2_reg;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	a_glitch_reject: assert property (@(posedge core_clk) disable iff (sys_rst)
		$changed(filt_n) |-> ($past(cnt_reg) == CYC - 8'h01))
		else $error("filtered level moved before the deglitch window");
endmodule : aps_deglitch

/* core/aps_params.svh */
`ifndef APS_PARAMS_SVH
`define APS_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define APS_CLK_NS        8
`define APS_DEGLITCH_NS   2000
`define APS_DEGLITCH_CYC  ((`APS_DEGLITCH_NS + `APS_CLK_NS - 1) / `APS_CLK_NS)
`define APS_SLPQ_US       200
`define APS_SLPQ_CYC      ((`APS_SLPQ_US * 1000 + `APS_CLK_NS - 1) / `APS_CLK_NS)
`define APS_CFG_MS        3
`define APS_CFG_CYC       ((`APS_CFG_MS * 1000000 + `APS_CLK_NS - 1) / `APS_CLK_NS)
`define APS_WAKE_MS       25
`define APS_WAKE_CYC      ((`APS_WAKE_MS * 1000000 + `APS_CLK_NS - 1) / `APS_CLK_NS)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define APS_CTRL_OFF      8'h00
`define APS_STATUS_OFF    8'h04
`define APS_IRQ_STAT_OFF  8'h08
`define APS_IRQ_CLR_OFF   8'h0c
`define APS_IRQ_EN_OFF    8'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define APS_CTRL_UV_EN    0
`define APS_CTRL_RST      32'h0000_0001
`define APS_EV_SLEEP      0
`define APS_EV_WAKE       1
`define APS_EV_FAULT      2
`define APS_EV_REFUSE     3
`define APS_EV_W          4

`endif

/* core/aps_pkg.sv */
package aps_pkg;
	// power state machine
	typedef enum logic [2:0] {
		APS_OFF, APS_SB_RAMP, APS_CFG_WAIT, APS_WAKE_WAIT,
		APS_ACTIVE, APS_SLP_QUAL, APS_S3, APS_S5
	} aps_state_t;
endpackage : aps_pkg

/* core/aps_power_ctrl.sv */
// Function
// - 3.3V dual on in active and S3; in soft-off on only if cfg is 0.
// - 5V dual on when active; in sleep on only if its cfg is 1.
// - memory plane on in active and S3, off in soft-off; voltage by select.
// - no direct S3 to soft-off move; illegal request combination holds state.
// - clock supply on only in active states.
// - standby 3.3V runs whenever standby bias is present.
// - standby ramp starts once bias passes power-on threshold.
// - 3ms after standby ramp, latch configuration, then bring up other planes.
// - active-switch gate drive on in active states only.
// - 3.3V dual sleep drive on in sleep states keeping that plane.
// - 5V standby switch on in sleep states keeping that plane.
// - memory external pass element driven in active states.
// - internal memory pass element regulates in sleep states keeping memory.
// - undervoltage watched on each of the five outputs only while that output is powered.
// - sleep requests filtered against glitches under about 2us.
// - configuration latched at sleep entry and frozen during sleep.
// - suspend request fall starts 200us timer; then soft-off or S3.
// - 25ms after main rails good before active-state drives turn on, unless a suspend request moves the wake wait to sleep qualification.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "aps_params.svh"

module aps_power_ctrl #(
	parameter int unsigned SLPQ_CYC = `APS_SLPQ_CYC,
	parameter int unsigned CFG_CYC  = `APS_CFG_CYC,
	parameter int unsigned WAKE_CYC = `APS_WAKE_CYC
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// sleep requests from the chipset
	input  wire logic        suspend_ram_req_n,
	input  wire logic        soft_off_req_n,
	// configuration pins
	input  wire logic        aux33_offstate_cfg,
	input  wire logic        dual5_sleep_cfg,
	input  wire logic        mem_voltage_select,
	// supply comparators
	input  wire logic        standby_bias_ok,
	input  wire logic        standby33_ramp_done,
	input  wire logic        main_rails_ok,
	input  wire logic        mem_plane_sense_uv,
	input  wire logic        aux33_plane_sense_uv,
	input  wire logic        dual5_plane_sense_uv,
	input  wire logic        standby33_uv,
	input  wire logic        clk_supply_uv,
	// plane drives
	output logic             standby33_out,
	output logic             active_switch_drive,
	output logic             aux33_sleep_drive,
	output logic             dual5_standby_switch,
	output logic             mem_active_drive,
	output logic             mem_sleep_pass_en,
	output logic             mem_sel_33,
	output logic             clk_supply_out,
	output logic             fault_or_memsel_pin,
	output logic             fault_or_memsel_pin_oe,
	output logic             irq,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import aps_pkg::*;

	aps_state_t          state_reg;
	aps_state_t          state_next;
	logic [31:0]         tmr_reg;
	logic [10:0]         pin_s1_reg;
	logic [10:0]         pin_s2_reg;
	logic                s3n;
	logic                s5n;
	logic                aux33_cfg_l;
	logic                dual5_cfg_l;
	logic                memsel_l;
	logic                latch_cfg;
	logic                refuse;
	logic                st_act;
	logic                st_sleep;
	logic                fault;
	logic [4:0]          uv_on;
	logic [`APS_EV_W-1:0] ev;
	logic [`APS_EV_W-1:0] irq_stat_reg;
	logic [`APS_EV_W-1:0] irq_en_reg;
	logic [31:0]         ctrl_reg;
	logic [7:0]          aw_addr_reg;
	logic [31:0]         w_data_reg;
	logic [3:0]          w_strb_reg;
	logic                wr_go;

	// ----------------------------------------
	// input conditioning
	// ----------------------------------------

	aps_deglitch u_dg_s3 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_n    (suspend_ram_req_n),
		.filt_n   (s3n)
	);

	aps_deglitch u_dg_s5 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_n    (soft_off_req_n),
		.filt_n   (s5n)
	);

	// all other pins are asynchronous levels
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1_reg <= 11'h000;
			pin_s2_reg <= 11'h000;
		end else begin
			pin_s1_reg <= {aux33_offstate_cfg, dual5_sleep_cfg, mem_voltage_select,
				standby_bias_ok, standby33_ramp_done, main_rails_ok,
				mem_plane_sense_uv, aux33_plane_sense_uv, dual5_plane_sense_uv,
				standby33_uv, clk_supply_uv};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// ----------------------------------------
	// power state machine
	// ----------------------------------------

	assign st_act   = (state_reg == APS_ACTIVE) || (state_reg == APS_SLP_QUAL);
	assign st_sleep = (state_reg == APS_S3) || (state_reg == APS_S5);

	// next state; from the cfg wait on, the illegal pair (s5n low, s3n high) holds the state while bias is present
	always_comb begin
		state_next = state_reg;
		latch_cfg  = 1'b0;
		refuse     = 1'b0;
		if (!pin_s2_reg[7]) begin
			state_next = APS_OFF; // bias gone, everything drops
		end else begin
			case (state_reg)
				APS_OFF: state_next = APS_SB_RAMP;
				APS_SB_RAMP: if (pin_s2_reg[6]) state_next = APS_CFG_WAIT;
				APS_CFG_WAIT: begin
					if (tmr_reg >= CFG_CYC - 1) begin
						if (!s5n && s3n) begin
							refuse = 1'b1;
						end else begin
							latch_cfg = 1'b1;
							if (s3n) state_next = APS_WAKE_WAIT;
							else if (s5n) state_next = APS_S3;
							else state_next = APS_S5;
						end
					end
				end
				APS_WAKE_WAIT: begin
					if (!s3n) state_next = APS_SLP_QUAL;
					else if (!s5n) refuse = 1'b1;
					else if (pin_s2_reg[5] && tmr_reg >= WAKE_CYC - 1)
						state_next = APS_ACTIVE;
				end
				APS_ACTIVE: begin
					if (!s3n) state_next = APS_SLP_QUAL;
					else if (!s5n) refuse = 1'b1;
				end
				APS_SLP_QUAL: begin
					if (s3n && s5n) state_next = APS_ACTIVE;
					else if (s3n) refuse = 1'b1;
					else if (tmr_reg >= SLPQ_CYC - 1) begin
						latch_cfg  = 1'b1;
						state_next = s5n ? APS_S3 : APS_S5;
					end
				end
				APS_S3: begin
					if (s3n && s5n) state_next = APS_WAKE_WAIT;
					else if (!s5n) refuse = 1'b1;
				end
				APS_S5: begin
					if (s3n && s5n) state_next = APS_WAKE_WAIT;
					else if (s3n || s5n) refuse = 1'b1; // both low is the held request
				end
				default: state_next = APS_OFF;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) state_reg <= APS_OFF;
		else state_reg <= state_next;
	end

	// one shared timer; the wake wait restarts while main rails are low
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tmr_reg <= 32'h0000_0000;
		end else if (state_next != state_reg ||
			(state_reg == APS_WAKE_WAIT && !pin_s2_reg[5])) begin
			tmr_reg <= 32'h0000_0000;
		end else if (tmr_reg != 32'hffff_ffff) begin
			tmr_reg <= tmr_reg + 32'h0000_0001;
		end
	end

	// config only sampled at latch points, so sleep-time changes are ignored
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aux33_cfg_l <= 1'b0;
			dual5_cfg_l <= 1'b0;
			memsel_l    <= 1'b0;
		end else if (latch_cfg) begin
			aux33_cfg_l <= pin_s2_reg[10];
			dual5_cfg_l <= pin_s2_reg[9];
			memsel_l    <= pin_s2_reg[8];
		end
	end

	// ----------------------------------------
	// plane drives
	// ----------------------------------------

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			standby33_out        <= 1'b0;
			active_switch_drive  <= 1'b0;
			aux33_sleep_drive    <= 1'b0;
			dual5_standby_switch <= 1'b0;
			mem_active_drive     <= 1'b0;
			mem_sleep_pass_en    <= 1'b0;
			mem_sel_33           <= 1'b0;
			clk_supply_out       <= 1'b0;
		end else begin
			standby33_out        <= (state_reg != APS_OFF);
			active_switch_drive  <= st_act;
			aux33_sleep_drive    <= (state_reg == APS_S3) ||
				(state_reg == APS_S5 && !aux33_cfg_l);
			dual5_standby_switch <= st_sleep && dual5_cfg_l;
			mem_active_drive     <= st_act;
			mem_sleep_pass_en    <= (state_reg == APS_S3);
			mem_sel_33           <= memsel_l;
			clk_supply_out       <= st_act;
		end
	end

	// ----------------------------------------
	// undervoltage monitor
	// ----------------------------------------

	// a plane that is off is low by design, so only powered ones count
	assign uv_on = {mem_active_drive | mem_sleep_pass_en,
		active_switch_drive | aux33_sleep_drive,
		active_switch_drive | dual5_standby_switch,
		standby33_out, clk_supply_out};
	assign fault = ctrl_reg[`APS_CTRL_UV_EN] && |(pin_s2_reg[4:0] & uv_on);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_or_memsel_pin    <= 1'b0;
			fault_or_memsel_pin_oe <= 1'b0;
		end else begin
			fault_or_memsel_pin    <= fault;
			fault_or_memsel_pin_oe <= fault;
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------

	assign ev[`APS_EV_SLEEP]  = (state_next == APS_S3 || state_next == APS_S5) && !st_sleep;
	assign ev[`APS_EV_WAKE]   = (state_next == APS_ACTIVE) && !st_act;
	assign ev[`APS_EV_FAULT]  = fault && !fault_or_memsel_pin_oe;
	assign ev[`APS_EV_REFUSE] = refuse;

	// a new event beats a clear in the same cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_go && aw_addr_reg == `APS_IRQ_CLR_OFF && w_strb_reg[0])
				irq_stat_reg <= (irq_stat_reg & ~w_data_reg[`APS_EV_W-1:0]) | ev;
			else
				irq_stat_reg <= irq_stat_reg | ev;
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// ----------------------------------------
	// axi4-lite slave
	// ----------------------------------------

	assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// address and data taken in either order; answer once both are held
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			aw_addr_reg   <= 8'h00;
			w_data_reg    <= 32'h0000_0000;
			w_strb_reg    <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				if (aw_addr_reg == `APS_CTRL_OFF || aw_addr_reg == `APS_IRQ_CLR_OFF ||
					aw_addr_reg == `APS_IRQ_EN_OFF)
					s_axi_bresp <= 2'h0;
				else
					s_axi_bresp <= 2'h2; // unmapped or read-only
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// writable registers, byte lane 0 only since fields are narrow
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg   <= `APS_CTRL_RST;
			irq_en_reg <= '0;
		end else if (wr_go && w_strb_reg[0]) begin
			if (aw_addr_reg == `APS_CTRL_OFF)
				ctrl_reg <= {31'h0, w_data_reg[`APS_CTRL_UV_EN]};
			else if (aw_addr_reg == `APS_IRQ_EN_OFF)
				irq_en_reg <= w_data_reg[`APS_EV_W-1:0];
		end
	end

	// read channel, one cycle to answer
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= 2'h0;
			if (s_axi_araddr == `APS_CTRL_OFF)
				s_axi_rdata <= ctrl_reg;
			else if (s_axi_araddr == `APS_STATUS_OFF)
				s_axi_rdata <= {22'h0, fault_or_memsel_pin_oe, memsel_l, dual5_cfg_l,
					aux33_cfg_l, s5n, s3n, 1'b0, state_reg};
			else if (s_axi_araddr == `APS_IRQ_STAT_OFF)
				s_axi_rdata <= {28'h0, irq_stat_reg};
			else if (s_axi_araddr == `APS_IRQ_EN_OFF)
				s_axi_rdata <= {28'h0, irq_en_reg};
			else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'h2;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_clk_sleep_off: assert property (
		st_sleep && $past(st_sleep) |-> !clk_supply_out)
		else $error("clock supply on during sleep");

	a_no_direct_sleep: assert property (
		(state_reg == APS_S3 |=> state_reg != APS_S5) and
		(state_reg == APS_S5 |=> state_reg != APS_S3))
		else $error("direct move between sleep states");

	a_qual_delay: assert property (
		state_reg == APS_SLP_QUAL && state_next != APS_SLP_QUAL && !s3n
		|-> tmr_reg >= SLPQ_CYC - 1)
		else $error("sleep entered before qualification time");

	a_aux33_soft_off: assert property (
		state_reg == APS_S5 && aux33_cfg_l |=> !aux33_sleep_drive)
		else $error("3.3V dual kept in soft-off with cfg 1");

	a_dual5_sleep_off: assert property (
		st_sleep && !dual5_cfg_l |=> !dual5_standby_switch && !active_switch_drive)
		else $error("5V dual powered in sleep with cfg 0");

	a_mem_soft_off: assert property (
		state_reg == APS_S5 ##1 state_reg == APS_S5 |-> !mem_sleep_pass_en && !mem_active_drive)
		else $error("memory plane powered in soft-off");

	a_cfg_frozen: assert property (
		st_sleep && $past(st_sleep) |-> $stable(aux33_cfg_l) && $stable(dual5_cfg_l))
		else $error("configuration changed during sleep");

	a_wake_timeout: assert property (
		state_reg == APS_WAKE_WAIT && state_next == APS_ACTIVE
		|-> tmr_reg >= WAKE_CYC - 1 && pin_s2_reg[5])
		else $error("active drives before main rails settled");

	a_standby_on: assert property (
		state_reg != APS_OFF ##1 state_reg != APS_OFF |-> standby33_out)
		else $error("standby output off while bias present");
endmodule : aps_power_ctrl

/* tb/acpi_power_plane_state_control_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bench top
// ----------------------------------------
module acpi_power_plane_state_control_tb;
	import aps_pkg::*;

	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	logic        bias     = 1'b0;
	logic [1:0]  slp_n    = 2'h3;
	logic        rails    = 1'b0;
	logic [4:0]  uv_cmd   = 5'h0;
	logic        aux_cfg  = 1'b0;
	logic        d5_cfg   = 1'b0;
	logic        msel     = 1'b1;
	wire logic   sus_n, off_n, bias_ok, ramp_done, rails_ok;
	wire logic [4:0] uv;
	logic        sb, act, aux, d5, ma, mp, s3, ck, flt_o, flt_oe, irq;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata  = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata, rdat;
	int          bad_count = 0;
	int          compares  = 0;

	aps_supply_model i_aps_supply_model (.core_clk(core_clk), .bias_cmd(bias),
		.sleep_cmd_n(slp_n), .rails_cmd(rails), .uv_cmd(uv_cmd), .standby33_out(sb),
		.suspend_ram_req_n(sus_n), .soft_off_req_n(off_n), .standby_bias_ok(bias_ok),
		.standby33_ramp_done(ramp_done), .main_rails_ok(rails_ok), .uv_flags(uv));

	aps_power_ctrl #(.SLPQ_CYC(20), .CFG_CYC(30), .WAKE_CYC(40)) i_aps_power_ctrl (
		.core_clk(core_clk), .sys_rst(sys_rst), .suspend_ram_req_n(sus_n),
		.soft_off_req_n(off_n), .aux33_offstate_cfg(aux_cfg), .dual5_sleep_cfg(d5_cfg),
		.mem_voltage_select(msel), .standby_bias_ok(bias_ok), .standby33_ramp_done(ramp_done),
		.main_rails_ok(rails_ok), .mem_plane_sense_uv(uv[0]), .aux33_plane_sense_uv(uv[1]),
		.dual5_plane_sense_uv(uv[2]), .standby33_uv(uv[3]), .clk_supply_uv(uv[4]),
		.standby33_out(sb), .active_switch_drive(act), .aux33_sleep_drive(aux),
		.dual5_standby_switch(d5), .mem_active_drive(ma), .mem_sleep_pass_en(mp),
		.mem_sel_33(s3), .clk_supply_out(ck), .fault_or_memsel_pin(flt_o),
		.fault_or_memsel_pin_oe(flt_oe), .irq(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// 125 MHz core clock
	always #4 core_clk = ~core_clk;

	task finish_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task hang(input string what);
		bad_count++;
		$display("Error %s wait ran out", what);
		finish_test();
	endtask : hang

	// one axi4-lite write; both channels offered together, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				rs = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			hang("write");
	endtask : wr

	// one axi4-lite read
	task rd(input logic [7:0] a);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				rdat = rdata;
				rs = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 50)
			hang("read");
	endtask : rd

	// poll the state field; plane outputs lag the state by a cycle
	task wait_state(input aps_state_t s);
		int n;
		for (n = 0; n < 400; n++) begin
			rd(8'h04);
			if (rdat[2:0] === s)
				break;
		end
		if (n == 400)
			hang("state");
		repeat (2) @(posedge core_clk);
	endtask : wait_state

	// order: standby, active switch, aux sleep, 5v switch, mem act, mem pass, clk, sel
	task planes(input logic [7:0] e);
		check("planes", 32'({sb, act, aux, d5, ma, mp, ck, s3}), 32'(e));
	endtask : planes

	task t_regs();
		rd(8'h00);
		check("ctrl reset", rdat, 32'h0000_0001);
		rd(8'h40);
		check("unmapped rresp", 32'(rs), 32'h2);
		check("unmapped rdata", rdat, 32'h0);
		wr(8'h04, 32'h0);
		check("status write bresp", 32'(rs), 32'h2);
		check("no bias standby", 32'(sb), 32'h0);
		$display("test regs done");
	endtask : t_regs

	task t_powerup();
		bias <= 1'b1;
		wait_state(APS_WAKE_WAIT);
		msel <= 1'b0;
		check("held until rails", 32'({sb, act, ck}), 32'h4);
		check("select latched", 32'(s3), 32'h1);
		rails <= 1'b1;
		wait_state(APS_ACTIVE);
		planes(8'hcb);
		$display("test powerup done");
	endtask : t_powerup

	task t_active_faults();
		int i;
		for (i = 0; i < 5; i++) begin
			uv_cmd <= 5'(1 << i);
			repeat (6) @(posedge core_clk);
			check("fault pin", 32'({flt_o, flt_oe}), 32'h3);
			uv_cmd <= 5'h0;
			repeat (6) @(posedge core_clk);
			check("fault clear", 32'({flt_o, flt_oe}), 32'h0);
		end
		wr(8'h00, 32'h0);
		uv_cmd <= 5'h01;
		repeat (6) @(posedge core_clk);
		check("fault masked", 32'({flt_o, flt_oe}), 32'h0);
		uv_cmd <= 5'h0;
		wr(8'h00, 32'h1);
		slp_n <= 2'b10;
		repeat (100) @(posedge core_clk);
		slp_n <= 2'b01;
		repeat (300) @(posedge core_clk);
		slp_n <= 2'b11;
		rd(8'h04);
		check("glitch ignored", 32'(rdat[2:0]), 32'(APS_ACTIVE));
		$display("test active faults done");
	endtask : t_active_faults

	task t_s3();
		int i;
		slp_n <= 2'b10;
		wait_state(APS_S3);
		planes(8'ha4);
		check("masked irq", 32'(irq), 32'h0);
		for (i = 0; i < 2; i++) begin
			slp_n <= 2'(i);
			repeat (300) @(posedge core_clk);
			rd(8'h04);
			check("refused move", 32'(rdat[2:0]), 32'(APS_S3));
		end
		wr(8'h10, 32'h8);
		repeat (3) @(posedge core_clk);
		check("irq raised", 32'(irq), 32'h1);
		wr(8'h0c, 32'h8);
		repeat (3) @(posedge core_clk);
		check("set beats clear", 32'(irq), 32'h1);
		slp_n <= 2'b10;
		// let both filters settle so the refused combination is gone
		repeat (300) @(posedge core_clk);
		wr(8'h0c, 32'h8);
		repeat (3) @(posedge core_clk);
		check("irq cleared", 32'(irq), 32'h0);
		wr(8'h10, 32'h0);
		slp_n <= 2'b11;
		wait_state(APS_ACTIVE);
		$display("test s3 done");
	endtask : t_s3

	task t_s5();
		aux_cfg <= 1'b1;
		d5_cfg <= 1'b1;
		repeat (4) @(posedge core_clk);
		slp_n <= 2'b00;
		wait_state(APS_S5);
		planes(8'h90);
		wr(8'h0c, 32'hf);
		rd(8'h08);
		check("soft-off not refused", rdat, 32'h0);
		aux_cfg <= 1'b0;
		slp_n <= 2'b10;
		repeat (300) @(posedge core_clk);
		rd(8'h04);
		check("refused s3", 32'(rdat[2:0]), 32'(APS_S5));
		check("cfg frozen", 32'(aux), 32'h0);
		bias <= 1'b0;
		wait_state(APS_OFF);
		check("bias lost", 32'(sb), 32'h0);
		$display("test s5 done");
	endtask : t_s5

	// reset, then the scenarios in order
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_powerup();
		t_active_faults();
		t_s3();
		t_s5();
		finish_test();
	end
endmodule : acpi_power_plane_state_control_tb

/* tb/aps_supply_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// chipset sleep pins and atx supply comparators
// ----------------------------------------
module aps_supply_model (
	// clock
	core_clk,
	// commands from the bench
	bias_cmd,
	sleep_cmd_n,
	rails_cmd,
	uv_cmd,
	// device feedback
	standby33_out,
	// pins into the device
	suspend_ram_req_n,
	soft_off_req_n,
	standby_bias_ok,
	standby33_ramp_done,
	main_rails_ok,
	uv_flags
);
	input  wire logic       core_clk;
	input  wire logic       bias_cmd;
	input  wire logic [1:0] sleep_cmd_n;
	input  wire logic       rails_cmd;
	input  wire logic [4:0] uv_cmd;
	input  wire logic       standby33_out;
	output wire logic       suspend_ram_req_n;
	output wire logic       soft_off_req_n;
	output wire logic       standby_bias_ok;
	output wire logic       standby33_ramp_done;
	output wire logic       main_rails_ok;
	output wire logic [4:0] uv_flags;

	logic [3:0] ramp_cnt = 4'h0;

	// ramp ends ten cycles after enable; a dropped regulator restarts it
	always @(posedge core_clk) begin
		if (!standby33_out)
			ramp_cnt <= 4'h0;
		else if (ramp_cnt != 4'ha)
			ramp_cnt <= ramp_cnt + 4'h1;
	end

	// bench commands change just after an edge, so the pins do too
	assign standby33_ramp_done = (ramp_cnt == 4'ha);
	assign suspend_ram_req_n   = sleep_cmd_n[0];
	assign soft_off_req_n      = sleep_cmd_n[1];
	assign standby_bias_ok     = bias_cmd;
	assign main_rails_ok       = rails_cmd;
	assign uv_flags            = uv_cmd;
endmodule : aps_supply_model
